// >>> rtl/icf_core_irq.sv
// interrupt enable and flag block: core control, peripheral flags and enables, combined request to the core
// assumes: Avalon-MM master holds each request until waitrequest is low; source inputs synchronous to clk
//
// How it works
// - peripheral enable byte holds converter/serial/capcomp/timer2/timer1 enables at 6,3,2,1,0, reset zero.
// - peripheral flag byte mirrors enable positions, resets zero, software reads and writes it.
// - peripheral sources reach the core only while the peripheral enable is set.
// - the global enable bit gates every request to the core.
// - flags set on their event whatever the enables hold.
// - converter flag sets when a conversion completes.
// - serial flag sets on every finished transfer in all serial modes.
// - in two-wire master mode, completed start/stop/restart/ack sequences also set it.
// - in the two-wire modes, start or stop seen on the bus while idle sets the serial flag.
// - capture sets the capcomp flag; PWM mode leaves it alone.
// - compare match sets the capcomp flag, held until software clears it.
// - timer two reaching its period sets its flag, held until cleared.
// - timer one 16-bit overflow sets its flag, held until cleared.
// - core control holds timer zero, port change and pin enables and flags, read/write.
// - pin flag sets on rising edge when edge select is one, falling when zero.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module icf_core_irq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [icf_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire icf_pkg::icf_src_t src,
  output logic core_irq
);
  import icf_pkg::*;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} icf_bus_st_t;

  // ************************************************************
  // declarations
  // ************************************************************
  icf_bus_st_t bus_st_r;
  logic [7:0] core_ctrl_r;
  logic [7:0] core_ctrl_nxt;
  logic [7:0] periph_flags_r;
  logic [7:0] periph_flags_nxt;
  logic [7:0] periph_en_r;
  logic [7:0] edge_opt_r;
  logic [7:0] readdata_r;
  logic [7:0] rd_byte;
  logic [7:0] pending;
  logic core_irq_r;
  logic irq_nxt;
  logic core_hit;
  logic periph_hit;
  logic bus_req;
  logic addr_ok;
  logic [7:0] idx;
  logic wr_ok;
  logic wr_core;
  logic wr_pflags;
  logic wr_pen;
  logic wr_edge;
  icf_set_t src_set;

  // ************************************************************
  // event sources
  // ************************************************************
  icf_event_detect u_detect (
    .clk(clk),
    .sys_rst(sys_rst),
    .src(src),
    .edge_rising(edge_opt_r[BIT_EDGE_SEL]),
    .src_set(src_set)
  );

  // ************************************************************
  // bus slave: one wait state on every access
  // ************************************************************
  assign bus_req = avs_read | avs_write;
  assign addr_ok = (avs_address[1:0] == 2'b00);
  assign idx = avs_address[ADDR_W-1:2];
  // a write lands only at the edge where waitrequest is low, and only with the low byte lane on
  assign wr_ok = (bus_st_r == BUS_ANSWER) && avs_write && avs_byteenable[0] && addr_ok;
  assign wr_core = wr_ok && idx == IDX_CORE_CTRL;
  assign wr_pflags = wr_ok && idx == IDX_PERIPH_FLAGS;
  assign wr_pen = wr_ok && idx == IDX_PERIPH_EN;
  assign wr_edge = wr_ok && idx == IDX_EDGE_OPT;
  assign avs_waitrequest = bus_req && (bus_st_r != BUS_ANSWER);
  assign avs_readdata = {24'h00_0000, readdata_r};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_st_r <= BUS_IDLE;
    end else begin
      unique case (bus_st_r)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_st_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: bus_st_r <= BUS_IDLE;
      endcase
    end
  end

  assign pending = {5'b0_0000, periph_hit, core_hit, core_irq_r};

  // unmapped and misaligned reads return zero
  always_comb begin
    rd_byte = 8'h00;
    if (addr_ok) begin
      unique case (idx)
        IDX_CORE_CTRL: rd_byte = core_ctrl_r;
        IDX_PERIPH_FLAGS: rd_byte = periph_flags_r;
        IDX_PERIPH_EN: rd_byte = periph_en_r;
        IDX_EDGE_OPT: rd_byte = edge_opt_r;
        IDX_PENDING: rd_byte = pending;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // read data are caught one cycle ahead so they stand from a flop while waitrequest is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_r <= 8'h00;
    end else if (bus_st_r == BUS_IDLE && avs_read) begin
      readdata_r <= rd_byte;
    end
  end

  // ************************************************************
  // core control: enables from software, flags set by hardware
  // ************************************************************
  // a set arriving with a clearing write wins, so no event is lost
  always_comb begin
    core_ctrl_nxt = core_ctrl_r;
    if (wr_core) begin
      core_ctrl_nxt = avs_writedata[7:0];
    end
    core_ctrl_nxt[BIT_T0_FLAG] = core_ctrl_nxt[BIT_T0_FLAG] | src_set.t0;
    core_ctrl_nxt[BIT_EXT_FLAG] = core_ctrl_nxt[BIT_EXT_FLAG] | src_set.ext;
    core_ctrl_nxt[BIT_PB_FLAG] = core_ctrl_nxt[BIT_PB_FLAG] | src_set.pb;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ctrl_r <= CORE_CTRL_RST;
    end else begin
      core_ctrl_r <= core_ctrl_nxt;
    end
  end

  // ************************************************************
  // peripheral flags and enables
  // ************************************************************
  // reserved positions hold no storage and read as zero
  always_comb begin
    periph_flags_nxt = periph_flags_r;
    if (wr_pflags) begin
      periph_flags_nxt = avs_writedata[7:0] & PERIPH_IMPL_MASK;
    end
    periph_flags_nxt[BIT_CONV] = periph_flags_nxt[BIT_CONV] | src_set.conv;
    periph_flags_nxt[BIT_SER] = periph_flags_nxt[BIT_SER] | src_set.ser;
    periph_flags_nxt[BIT_CC] = periph_flags_nxt[BIT_CC] | src_set.cc;
    periph_flags_nxt[BIT_T2] = periph_flags_nxt[BIT_T2] | src_set.t2;
    periph_flags_nxt[BIT_T1] = periph_flags_nxt[BIT_T1] | src_set.t1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_flags_r <= PERIPH_FLAGS_RST;
    end else begin
      periph_flags_r <= periph_flags_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_en_r <= PERIPH_EN_RST;
    end else if (wr_pen) begin
      periph_en_r <= avs_writedata[7:0] & PERIPH_IMPL_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_opt_r <= EDGE_OPT_RST;
    end else if (wr_edge) begin
      edge_opt_r <= avs_writedata[7:0] & EDGE_OPT_MASK;
    end
  end

  // ************************************************************
  // combined request to the core
  // ************************************************************
  // no acknowledge input: the request drops only once software clears a flag or an enable
  assign core_hit = (core_ctrl_r[BIT_T0_EN] & core_ctrl_r[BIT_T0_FLAG])
    | (core_ctrl_r[BIT_EXT_EN] & core_ctrl_r[BIT_EXT_FLAG])
    | (core_ctrl_r[BIT_PB_EN] & core_ctrl_r[BIT_PB_FLAG]);
  assign periph_hit = |(periph_en_r & periph_flags_r & PERIPH_IMPL_MASK);
  assign irq_nxt = core_ctrl_r[BIT_GLOBAL_EN]
    & (core_hit | (core_ctrl_r[BIT_PERIPH_EN] & periph_hit));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_r <= 1'b0;
    end else begin
      core_irq_r <= irq_nxt;
    end
  end

  assign core_irq = core_irq_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pen_write: assert property (
    wr_pen |=> periph_en_r == ($past(avs_writedata[7:0]) & PERIPH_IMPL_MASK))
    else $error("peripheral enable write not stored");

  a_pflag_write: assert property (
    wr_pflags && src_set == '0 |=> periph_flags_r == ($past(avs_writedata[7:0]) & PERIPH_IMPL_MASK))
    else $error("peripheral flag write not stored");

  a_periph_gate: assert property (
    !core_ctrl_r[BIT_PERIPH_EN] && !core_hit |=> !core_irq_r)
    else $error("peripheral request passed with peripheral enable clear");

  a_global_gate: assert property (
    !core_ctrl_r[BIT_GLOBAL_EN] |=> !core_irq_r)
    else $error("request passed with global enable clear");

  a_flag_ignores_enable: assert property (
    src_set.t1 && periph_en_r == 8'h00 && core_ctrl_r[7:6] == 2'b00 |=> periph_flags_r[BIT_T1])
    else $error("flag did not set while disabled");

  a_conv_flag: assert property (
    src.conv_done |=> periph_flags_r[BIT_CONV])
    else $error("conversion completion not flagged");

  a_ser_xfer: assert property (
    src.ser_xfer_done |=> periph_flags_r[BIT_SER])
    else $error("serial transfer not flagged");

  a_ser_master_seq: assert property (
    src.ser_seq_done && src.ser_mode == SER_I2C_MASTER |=> periph_flags_r[BIT_SER])
    else $error("master sequence completion not flagged");

  a_ser_idle_cond: assert property (
    src.ser_mode != SER_SPI && src.ser_idle && (src.bus_start_seen || src.bus_stop_seen)
    |=> periph_flags_r[BIT_SER])
    else $error("idle bus start or stop not flagged");

  a_cc_capture_pwm: assert property (
    src.cc_mode == CC_PWM && !periph_flags_r[BIT_CC] && !wr_pflags |=> !periph_flags_r[BIT_CC])
    else $error("capcomp flag set in pwm mode");

  a_cc_hold: assert property (
    src.cc_mode == CC_COMPARE && src.cc_match ##1 !wr_pflags [*2] |-> periph_flags_r[BIT_CC])
    else $error("compare flag lost before software clear");

  a_t2_flag: assert property (
    src_set.t2 |=> periph_flags_r[BIT_T2])
    else $error("timer two match not flagged");

  a_t1_flag: assert property (
    src_set.t1 |=> periph_flags_r[BIT_T1])
    else $error("timer one overflow not flagged");

  a_pb_flag: assert property (
    src_set.pb |=> core_ctrl_r[BIT_PB_FLAG])
    else $error("port change not flagged");

  a_core_write: assert property (
    wr_core |=> core_ctrl_r[7:3] == $past(avs_writedata[7:3]))
    else $error("core control enables not stored");

  a_ext_flag: assert property (
    src_set.ext |=> core_ctrl_r[BIT_EXT_FLAG])
    else $error("pin edge not flagged");

  a_irq_formula: assert property (
    ##1 core_irq_r == ($past(core_ctrl_r[BIT_GLOBAL_EN]) && ($past(core_hit)
      || ($past(core_ctrl_r[BIT_PERIPH_EN]) && $past(periph_hit)))))
    else $error("core request does not match enables and flags");

  a_flag_sticky: assert property (
    ##1 (!$past(core_ctrl_r[BIT_T0_FLAG]) || $past(wr_core) || core_ctrl_r[BIT_T0_FLAG])
      && (!$past(periph_flags_r[BIT_SER]) || $past(wr_pflags) || periph_flags_r[BIT_SER]))
    else $error("flag cleared without a software write");

  a_t0_flag: assert property (
    src_set.t0 |=> core_ctrl_r[BIT_T0_FLAG])
    else $error("timer zero rollover not flagged");

  a_bus_one_wait: assert property (
    bus_req && bus_st_r == BUS_IDLE |-> avs_waitrequest ##1 !avs_waitrequest || !bus_req)
    else $error("bus answer not after one wait state");

endmodule : icf_core_irq

// >>> rtl/icf_event_detect.sv
// event detector: turns raw counter values, pins and peripheral strobes into one-cycle set pulses
// assumes: all inputs synchronous to clk; peripheral strobes are one-cycle pulses
`timescale 1ns/1ps
module icf_event_detect (
  input wire logic clk,
  input wire logic sys_rst,
  input wire icf_pkg::icf_src_t src,
  input wire logic edge_rising,
  output icf_pkg::icf_set_t src_set
);
  import icf_pkg::*;

  logic primed_r;
  logic [T0_W-1:0] t0_prev_r;
  logic [T1_W-1:0] t1_prev_r;
  logic t2_eq_r;
  logic pin_prev_r;
  logic [PB_W-1:0] pb_prev_r;
  logic t2_eq;

  assign t2_eq = (src.t2_count == src.t2_period);

  // history flops; primed_r masks the first cycle so reset values fake no edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primed_r <= 1'b0;
      t0_prev_r <= '0;
      t1_prev_r <= '0;
      t2_eq_r <= 1'b0;
      pin_prev_r <= 1'b0;
      pb_prev_r <= '0;
    end else begin
      primed_r <= 1'b1;
      t0_prev_r <= src.t0_count;
      t1_prev_r <= src.t1_count;
      t2_eq_r <= t2_eq;
      pin_prev_r <= src.ext_pin;
      pb_prev_r <= src.portb_hi;
    end
  end

  always_comb begin
    src_set = '0;
    src_set.t0 = primed_r && t0_prev_r == T0_TOP && src.t0_count == '0;
    src_set.t1 = primed_r && t1_prev_r == T1_TOP && src.t1_count == '0;
    src_set.t2 = primed_r && t2_eq && !t2_eq_r;
    src_set.ext = primed_r && (edge_rising ? (src.ext_pin && !pin_prev_r) : (!src.ext_pin && pin_prev_r));
    src_set.pb = primed_r && (src.portb_hi != pb_prev_r);
    src_set.conv = src.conv_done;
    // start/stop seen on an idle bus only means something in the two-wire modes
    src_set.ser = src.ser_xfer_done
      | (src.ser_mode == SER_I2C_MASTER && src.ser_seq_done)
      | (src.ser_mode != SER_SPI && src.ser_idle && (src.bus_start_seen || src.bus_stop_seen));
    unique case (src.cc_mode)
      CC_CAPTURE: src_set.cc = src.cc_capture;
      CC_COMPARE: src_set.cc = src.cc_match;
      CC_OFF, CC_PWM: src_set.cc = 1'b0;
    endcase
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_t1_wrap_seen: assert property (
    primed_r && src.t1_count == '0 && $past(src.t1_count) == T1_TOP |-> src_set.t1)
    else $error("timer one overflow not flagged");
  a_t2_match_once: assert property (
    src_set.t2 |=> !src_set.t2 || !$stable(src.t2_period) || !$stable(src.t2_count))
    else $error("timer two match repeated on a held match");
  a_pb_change_seen: assert property (
    primed_r && $stable(src.portb_hi) |-> !src_set.pb)
    else $error("port change flagged without a change");
  a_ext_edge_polarity: assert property (
    primed_r && $rose(src.ext_pin) |-> src_set.ext == edge_rising)
    else $error("external edge polarity wrong");

endmodule : icf_event_detect

// >>> rtl/icf_pkg.sv
// package: register map, bit layout, reset values, modes and carrier types of the interrupt flag block
// assumes: one clock domain; 8-bit registers sit in the low byte of 32-bit bus words
package icf_pkg;

  // ************************************************************
  // register map (index; byte address is four times the index)
  // ************************************************************
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CORE_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_PERIPH_EN = 8'h8c;
  localparam logic [7:0] IDX_EDGE_OPT = 8'h81;
  localparam logic [7:0] IDX_PENDING = 8'hf0;

  // ************************************************************
  // reset values and implemented-bit masks
  // ************************************************************
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAGS_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] EDGE_OPT_RST = 8'h40;
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'h4f;
  localparam logic [7:0] EDGE_OPT_MASK = 8'h40;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_T0_EN = 5;
  localparam int unsigned BIT_EXT_EN = 4;
  localparam int unsigned BIT_PB_EN = 3;
  localparam int unsigned BIT_T0_FLAG = 2;
  localparam int unsigned BIT_EXT_FLAG = 1;
  localparam int unsigned BIT_PB_FLAG = 0;
  localparam int unsigned BIT_CONV = 6;
  localparam int unsigned BIT_SER = 3;
  localparam int unsigned BIT_CC = 2;
  localparam int unsigned BIT_T2 = 1;
  localparam int unsigned BIT_T1 = 0;
  localparam int unsigned BIT_EDGE_SEL = 6;
  localparam int unsigned BIT_PEND_IRQ = 0;
  localparam int unsigned BIT_PEND_CORE = 1;
  localparam int unsigned BIT_PEND_PERIPH = 2;

  // ************************************************************
  // source counters
  // ************************************************************
  localparam int unsigned T0_W = 8;
  localparam int unsigned T1_W = 16;
  localparam int unsigned T2_W = 8;
  localparam int unsigned PB_W = 4;
  localparam logic [T0_W-1:0] T0_TOP = 8'hff;
  localparam logic [T1_W-1:0] T1_TOP = 16'hffff;

  // ************************************************************
  // modes and carriers
  // ************************************************************
  typedef enum logic [1:0] {SER_SPI, SER_I2C_SLAVE, SER_I2C_MASTER} icf_ser_mode_t;
  typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_PWM} icf_cc_mode_t;

  typedef struct packed {
    logic [T0_W-1:0] t0_count;
    logic [T1_W-1:0] t1_count;
    logic [T2_W-1:0] t2_count;
    logic [T2_W-1:0] t2_period;
    logic ext_pin;
    logic [PB_W-1:0] portb_hi;
    logic conv_done;
    icf_ser_mode_t ser_mode;
    logic ser_xfer_done;
    logic ser_seq_done;
    logic ser_idle;
    logic bus_start_seen;
    logic bus_stop_seen;
    icf_cc_mode_t cc_mode;
    logic cc_capture;
    logic cc_match;
  } icf_src_t;

  typedef struct packed {
    logic t0;
    logic ext;
    logic pb;
    logic conv;
    logic ser;
    logic cc;
    logic t2;
    logic t1;
  } icf_set_t;

endpackage : icf_pkg

// >>> tb/icf_src_model.sv
// partner model: peripheral event sources and pins that feed the interrupt flag block
// assumes: the bench calls its tasks; every change lands right after a rising edge
`timescale 1ns/1ps
module icf_src_model (
  input wire logic clk,
  output icf_pkg::icf_src_t src
);
  import icf_pkg::*;
  // ************************************************************
  // event sources
  // ************************************************************
  initial begin
    src = '0;
    // nonzero period so an idle count of zero is never a match
    src.t2_period = 8'h80;
    src.ser_idle = 1'b1;
  end
  task automatic strobe(input int k);
    @(posedge clk);
    case (k)
      0: src.conv_done <= 1'b1;
      1: src.ser_xfer_done <= 1'b1;
      2: src.ser_seq_done <= 1'b1;
      3: src.bus_start_seen <= 1'b1;
      4: src.bus_stop_seen <= 1'b1;
      5: src.cc_capture <= 1'b1;
      default: src.cc_match <= 1'b1;
    endcase
    @(posedge clk);
    {src.conv_done, src.ser_xfer_done, src.ser_seq_done, src.bus_start_seen} <= 4'h0;
    {src.bus_stop_seen, src.cc_capture, src.cc_match} <= 3'h0;
  endtask : strobe
  task automatic wrap(input int k);
    @(posedge clk);
    case (k)
      0: src.t0_count <= T0_TOP;
      1: src.t1_count <= T1_TOP;
      default: src.t2_count <= src.t2_period;
    endcase
    @(posedge clk);
    src.t0_count <= '0;
    src.t1_count <= '0;
    src.t2_count <= '0;
  endtask : wrap
  task automatic pins(input logic e, input logic [3:0] pb);
    @(posedge clk);
    src.ext_pin <= e;
    src.portb_hi <= pb;
    @(posedge clk);
  endtask : pins
  task automatic modes(input icf_ser_mode_t s, input icf_cc_mode_t c);
    @(posedge clk);
    src.ser_mode <= s;
    src.cc_mode <= c;
  endtask : modes
  task automatic levels(input logic idle, input logic [7:0] per);
    @(posedge clk);
    src.ser_idle <= idle;
    src.t2_period <= per;
  endtask : levels
endmodule : icf_src_model

// >>> tb/tb_top.sv
// testbench: register accesses over Avalon-MM and source events, with expected flag and request values
// assumes: one wait state per access is not relied on; the source model drives src
`timescale 1ns/1ps
module tb_top;
  import icf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  icf_src_t src;
  logic core_irq;
  int err_count = 0;
  int total_checks = 0;
  localparam logic [9:0] A_CT = {IDX_CORE_CTRL, 2'b00};
  localparam logic [9:0] A_PF = {IDX_PERIPH_FLAGS, 2'b00};
  localparam logic [9:0] A_PE = {IDX_PERIPH_EN, 2'b00};
  localparam logic [9:0] A_EO = {IDX_EDGE_OPT, 2'b00};
  always #2 clk = ~clk;
  icf_core_irq icf_core_irq_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src(src), .core_irq(core_irq));
  icf_src_model icf_src_model_i (.clk(clk), .src(src));
  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h00_0000, d};
    // request held until the edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("[ERR] waitrequest exp 0 got stuck");
      final_report();
    end
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic irq(input logic e);
    // request is registered after the flag, so let it settle
    repeat (3) @(posedge clk);
    chk("core_irq", {7'h00, e}, {7'h00, core_irq});
  endtask : irq
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(A_CT, 8'h00);
    rd(A_PF, 8'h00);
    rd(A_PE, 8'h00);
    rd(A_EO, 8'h40);
    rd(10'h100, 8'h00);
    // a write with the low byte lane off must not land
    avs_byteenable <= 4'h0;
    wr(A_PE, 8'h4f);
    avs_byteenable <= 4'h1;
    rd(A_PE, 8'h00);
    $display("test reset done");
    icf_src_model_i.strobe(0);
    icf_src_model_i.strobe(6);
    rd(A_PF, 8'h40);
    icf_src_model_i.strobe(1);
    rd(A_PF, 8'h48);
    icf_src_model_i.modes(SER_SPI, CC_CAPTURE);
    icf_src_model_i.strobe(5);
    rd(A_PF, 8'h4c);
    icf_src_model_i.wrap(2);
    rd(A_PF, 8'h4e);
    icf_src_model_i.wrap(1);
    rd(A_PF, 8'h4f);
    irq(1'b0);
    icf_src_model_i.strobe(3);
    wr(A_PF, 8'h00);
    rd(A_PF, 8'h00);
    for (int i = 1; i < 3; i++) begin
      icf_src_model_i.modes(icf_ser_mode_t'(i), CC_COMPARE);
      icf_src_model_i.strobe(1);
      rd(A_PF, 8'h08);
      wr(A_PF, 8'h00);
      icf_src_model_i.strobe(2);
      rd(A_PF, (i == 2) ? 8'h08 : 8'h00);
      wr(A_PF, 8'h00);
    end
    icf_src_model_i.strobe(3);
    rd(A_PF, 8'h08);
    wr(A_PF, 8'h00);
    icf_src_model_i.strobe(4);
    rd(A_PF, 8'h08);
    wr(A_PF, 8'h00);
    icf_src_model_i.levels(1'b0, 8'h20);
    icf_src_model_i.strobe(3);
    rd(A_PF, 8'h00);
    icf_src_model_i.levels(1'b1, 8'h20);
    icf_src_model_i.wrap(2);
    rd(A_PF, 8'h02);
    wr(A_PF, 8'h00);
    icf_src_model_i.strobe(6);
    rd(A_PF, 8'h04);
    wr(A_PF, 8'h00);
    icf_src_model_i.modes(SER_SPI, CC_PWM);
    icf_src_model_i.strobe(5);
    rd(A_PF, 8'h00);
    $display("test peripheral flags done");
    icf_src_model_i.wrap(0);
    rd(A_CT, 8'h04);
    icf_src_model_i.pins(1'b1, 4'h0);
    rd(A_CT, 8'h06);
    icf_src_model_i.pins(1'b1, 4'ha);
    rd(A_CT, 8'h07);
    wr(A_CT, 8'h00);
    wr(A_EO, 8'h00);
    icf_src_model_i.pins(1'b0, 4'ha);
    rd(A_CT, 8'h02);
    wr(A_CT, 8'h00);
    icf_src_model_i.pins(1'b1, 4'ha);
    rd(A_CT, 8'h00);
    $display("test core flags done");
    wr(A_PE, 8'h40);
    icf_src_model_i.strobe(0);
    wr(A_CT, 8'h80);
    irq(1'b0);
    rd(10'h3c0, 8'h04);
    wr(A_CT, 8'hc0);
    irq(1'b1);
    rd(10'h3c0, 8'h05);
    wr(A_CT, 8'h40);
    irq(1'b0);
    rd(A_PF, 8'h40);
    wr(A_PF, 8'h00);
    wr(A_CT, 8'ha0);
    icf_src_model_i.wrap(0);
    irq(1'b1);
    wr(A_CT, 8'ha0);
    irq(1'b0);
    $display("test request gating done");
    // second reset in mid-run: written state must return to reset values
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(A_CT, 8'h00);
    rd(A_PE, 8'h00);
    rd(A_EO, 8'h40);
    irq(1'b0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb_top
